// ---- design/btau_pkg.sv ----
// branch target address unit package: modes, vector locations and field layouts
// assumes a 16-bit program address space and byte-wide memory reads
package btau_pkg;

  // ---------------------------------------------------------------
  // widths and fixed memory locations
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] RESET_VEC_LO = 16'h0000;
  localparam logic [15:0] RESET_VEC_HI = 16'h0001;
  localparam logic [15:0] FIXED_AREA_BASE = 16'h0800;
  localparam logic [15:0] TABLE_BASE = 16'h0040;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned DISP_SIGN_BIT = 7;
  localparam int unsigned IDX_LSB = 1;
  localparam int unsigned IDX_MSB = 5;
  localparam int unsigned FIXED_W = 11;

  // next-pc selection requested by the decoder
  typedef enum logic [2:0] {
    BTAU_SEQ,
    BTAU_REL,
    BTAU_ABS16,
    BTAU_FIXED,
    BTAU_TABLE,
    BTAU_REGPAIR
  } btau_mode_e;

endpackage

// ---- design/btau_target_calc.sv ----
// combinational target calculator for non-table branch modes
// assumes the caller supplies the pc already stepped past the instruction
`timescale 1ns/1ns
module btau_target_calc (
  // selection
  input wire btau_pkg::btau_mode_e mode,
  // operands
  input wire logic [15:0] next_instr_addr,
  input wire logic [7:0] relative_displacement,
  input wire logic [15:0] full_target_operand,
  input wire logic [10:0] fixed_area_operand,
  input wire logic [15:0] accumulator_pair,
  // result
  output logic [15:0] target
);

  logic [15:0] disp_ext;

  // sign extension copies bit 7 into all upper bits
  assign disp_ext = {{8{relative_displacement[btau_pkg::DISP_SIGN_BIT]}},
                     relative_displacement}; // [RULE3] [RULE4]

  // select target; adds are 16 bits wide so carry out of bit 15 drops
  always_comb begin
    case (mode)
      btau_pkg::BTAU_REL: target = next_instr_addr + disp_ext; // [RULE2] [RULE13]
      btau_pkg::BTAU_ABS16: target = full_target_operand; // [RULE6]
      btau_pkg::BTAU_FIXED: target = btau_pkg::FIXED_AREA_BASE |
                                     {5'h00, fixed_area_operand}; // [RULE7]
      btau_pkg::BTAU_REGPAIR: target = accumulator_pair; // [RULE9]
      default: target = next_instr_addr;
    endcase
  end

endmodule // btau_target_calc

// ---- design/btau_unit.sv ----
// branch target address unit: owns the program counter of the core
// assumes decoder pulses instr_valid once per instruction, with operands stable;
// memory answers a read on mem_rd_data within the cycle in which mem_rd_req stands
//
// What this block does
// [RULE1] sequential flow adds instruction byte length to the program counter
// [RULE2] relative branch target is next instruction start plus 8-bit displacement
// [RULE3] displacement is signed two's complement, sign in bit 7, -128..+127
// [RULE4] displacement is sign-extended to 16 bits before the add
// [RULE5] short unconditional and all conditional branches use relative targets
// [RULE6] 16-bit immediate call and jump load the operand directly
// [RULE7] fixed-area call targets lie within 0800h through 0fffh from 11 bits
// [RULE8] table call uses opcode bits 1..5 to pick entry in 40h..7fh
// [RULE9] register jump copies the accumulator pair into the program counter
// [RULE10] program counter is a 16-bit register holding next address
// [RULE11] reset loads program counter from vector bytes at 0000h and 0001h
// [RULE12] vector entries read low byte at even address, high byte next
// [RULE13] relative arithmetic wraps modulo 65536, carry from bit 15 dropped
`timescale 1ns/1ns
module btau_unit (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // decoder request
  input wire logic instr_valid,
  input wire btau_pkg::btau_mode_e mode,
  input wire logic branch_taken,
  input wire logic [2:0] instr_len,
  input wire logic [7:0] relative_displacement,
  input wire logic [15:0] full_target_operand,
  input wire logic [10:0] fixed_area_operand,
  input wire logic [7:0] opcode,
  // register file
  input wire logic [15:0] accumulator_pair,
  // vector memory read port
  output logic mem_rd_req,
  output logic [15:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  // fetch unit
  output logic [15:0] program_counter,
  output logic pc_valid,
  output logic busy
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_VEC_LO,
    ST_VEC_HI,
    ST_VEC_DONE,
    ST_RUN
  } btau_state_e;

  typedef struct packed {
    btau_state_e st;
    logic [15:0] pc;
    logic [15:0] vec_addr;
    logic [7:0] lo_byte;
    logic rd_req;
    logic pc_valid;
    logic busy;
  } btau_regs_s;

  btau_regs_s r_reg;
  btau_regs_s r_next;
  logic [15:0] seq_pc;
  logic [15:0] calc_target;
  logic [15:0] table_addr;
  btau_pkg::btau_mode_e eff_mode;

  // ---------------------------------------------------------------
  // target arithmetic
  // ---------------------------------------------------------------
  // step past the whole instruction; relative targets build on this
  assign seq_pc = r_reg.pc + {13'h0000, instr_len}; // [RULE1]
  // untaken conditional branches fall through to the sequential address
  assign eff_mode = (mode == btau_pkg::BTAU_REL && !branch_taken) ?
                    btau_pkg::BTAU_SEQ : mode; // [RULE5]
  // table entry word address: base + 2*index, bits 1..5 already form 2*index
  assign table_addr = btau_pkg::TABLE_BASE |
                      {10'h000, opcode[btau_pkg::IDX_MSB:btau_pkg::IDX_LSB], 1'b0}; // [RULE8]

  btau_target_calc u_calc (
    .mode(eff_mode),
    .next_instr_addr(seq_pc),
    .relative_displacement(relative_displacement),
    .full_target_operand(full_target_operand),
    .fixed_area_operand(fixed_area_operand),
    .accumulator_pair(accumulator_pair),
    .target(calc_target)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // vector fetch shared by reset and table call; requests ignored while busy
  always_comb begin
    r_next = r_reg;
    r_next.rd_req = 1'b0;
    r_next.pc_valid = 1'b0;
    case (r_reg.st)
      ST_VEC_LO: begin
        r_next.rd_req = 1'b1;
        r_next.st = ST_VEC_HI;
      end
      ST_VEC_HI: begin
        r_next.lo_byte = mem_rd_data; // low byte at even address [RULE12]
        r_next.vec_addr = r_reg.vec_addr + 16'h0001;
        r_next.rd_req = 1'b1;
        r_next.st = ST_VEC_DONE;
      end
      ST_VEC_DONE: begin
        r_next.pc = {mem_rd_data, r_reg.lo_byte}; // [RULE8] [RULE11] [RULE12]
        r_next.pc_valid = 1'b1;
        r_next.busy = 1'b0;
        r_next.st = ST_RUN;
      end
      ST_RUN: begin
        if (instr_valid) begin
          if (mode == btau_pkg::BTAU_TABLE) begin
            r_next.vec_addr = table_addr; // [RULE8]
            r_next.busy = 1'b1;
            r_next.st = ST_VEC_LO;
          end else begin
            r_next.pc = calc_target; // [RULE10]
            r_next.pc_valid = 1'b1;
          end
        end
      end
      default: r_next.st = ST_RUN;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // reset starts the vector fetch from the reset vector location
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r_reg.st <= ST_VEC_LO;
      r_reg.pc <= btau_pkg::PC_RESET;
      r_reg.vec_addr <= btau_pkg::RESET_VEC_LO; // [RULE11]
      r_reg.lo_byte <= 8'h00;
      r_reg.rd_req <= 1'b0;
      r_reg.pc_valid <= 1'b0;
      r_reg.busy <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign mem_rd_req = r_reg.rd_req;
  assign mem_rd_addr = r_reg.vec_addr;
  assign program_counter = r_reg.pc;
  assign pc_valid = r_reg.pc_valid;
  assign busy = r_reg.busy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  seq_step_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE1]
    (r_reg.st == ST_RUN && instr_valid && mode == btau_pkg::BTAU_SEQ) |=>
    program_counter == $past(program_counter) + {13'h0000, $past(instr_len)})
    else $error("sequential step wrong");

  rel_target_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE2]
    (r_reg.st == ST_RUN && instr_valid && mode == btau_pkg::BTAU_REL && branch_taken) |=>
    program_counter == 16'($past(program_counter) + {13'h0000, $past(instr_len)}
      + {{8{$past(relative_displacement[7])}}, $past(relative_displacement)}))
    else $error("relative target wrong");

  rel_untaken_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE5]
    (r_reg.st == ST_RUN && instr_valid && mode == btau_pkg::BTAU_REL && !branch_taken) |=>
    program_counter == $past(program_counter) + {13'h0000, $past(instr_len)})
    else $error("untaken branch moved pc");

  abs_load_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE6]
    (r_reg.st == ST_RUN && instr_valid && mode == btau_pkg::BTAU_ABS16) |=>
    program_counter == $past(full_target_operand))
    else $error("absolute target wrong");

  fixed_area_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE7]
    (r_reg.st == ST_RUN && instr_valid && mode == btau_pkg::BTAU_FIXED) |=>
    program_counter[15:11] == 5'h01 && program_counter[10:0] == $past(fixed_area_operand))
    else $error("fixed area target wrong");

  regpair_load_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE9]
    (r_reg.st == ST_RUN && instr_valid && mode == btau_pkg::BTAU_REGPAIR) |=>
    program_counter == $past(accumulator_pair))
    else $error("register jump target wrong");

  table_fetch_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE8]
    (r_reg.st == ST_RUN && instr_valid && mode == btau_pkg::BTAU_TABLE) |=>
    ##1 mem_rd_req && mem_rd_addr[15:7] == 9'h000 && mem_rd_addr[6] && !mem_rd_addr[0]
    ##1 mem_rd_req ##1 pc_valid)
    else $error("table fetch sequence wrong");

  vec_pair_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE12]
    (r_reg.st == ST_VEC_DONE) |=>
    program_counter == {$past(mem_rd_data), $past(mem_rd_data, 2)})
    else $error("vector byte order wrong");

  reset_vec_a: assert property (@(posedge core_clk) // [RULE11]
    $rose(rst_b) |-> mem_rd_addr == btau_pkg::RESET_VEC_LO ##1 mem_rd_req
    ##1 mem_rd_req && mem_rd_addr == btau_pkg::RESET_VEC_HI ##1 pc_valid)
    else $error("reset vector fetch wrong");

endmodule // btau_unit

// ---- verification/btau_mem_model.sv ----
// vector memory seen by the branch target unit: answers within the request cycle
// assumes the unit samples mem_rd_data at the edge that closes its request cycle
`timescale 1ns/1ns
module btau_mem_model (
  // read port
  input wire logic mem_rd_req,
  input wire logic [15:0] mem_rd_addr,
  output logic [7:0] mem_rd_data
);
  // byte at address a is a[7:0] ^ 3c, so low and high vector bytes differ
  // without a request the bus shows the inverse, so stale data never passes
  assign mem_rd_data = (mem_rd_req === 1'b1) ? (mem_rd_addr[7:0] ^ 8'h3c) :
                       ~(mem_rd_addr[7:0] ^ 8'h3c);
endmodule // btau_mem_model

// ---- verification/testbench.sv ----
// self-checking bench for the branch target address unit
// assumes the vector memory model answers with byte a[7:0] ^ 3c
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0, branch_taken = 1'b0;
  btau_pkg::btau_mode_e mode = btau_pkg::BTAU_SEQ;
  logic [2:0] instr_len = 3'h1;
  logic [7:0] disp = 8'h00, opcode = 8'h00, mem_rd_data;
  logic [15:0] full = 16'h0000, acc = 16'h0000, exp_pc, mem_rd_addr, program_counter;
  logic [10:0] fixed = 11'h000;
  logic mem_rd_req, pc_valid, busy;
  int n_errors = 0, num_checks = 0;
  logic [7:0] dtab [4] = '{8'h7f, 8'h80, 8'h00, 8'hff};

  always #2 core_clk = ~core_clk;

  btau_unit u_btau_unit (.core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .mode(mode), .branch_taken(branch_taken), .instr_len(instr_len),
    .relative_displacement(disp), .full_target_operand(full), .fixed_area_operand(fixed),
    .opcode(opcode), .accumulator_pair(acc), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .program_counter(program_counter), .pc_valid(pc_valid), .busy(busy));
  btau_mem_model u_btau_mem_model (.mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // waits for the one-cycle update pulse, then compares the counter
  task wait_pc;
    int i;
    for (i = 0; i < 8; i++) begin
      if (pc_valid === 1'b1) break;
      @(negedge core_clk);
    end
    check({15'h0, pc_valid}, 16'h0001);
    check(program_counter, exp_pc);
  endtask

  // one request; the spare edge up front keeps valid from two writes in one step
  task issue(input btau_pkg::btau_mode_e m, input logic [2:0] len, input logic tk);
    @(negedge core_clk);
    mode = m;
    instr_len = len;
    branch_taken = tk;
    instr_valid = 1'b1;
    @(negedge core_clk);
    instr_valid = 1'b0;
    wait_pc();
  endtask

  task sc_reset;
    int i;
    rst_b = 1'b0;
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    for (i = 0; i < 10 && busy !== 1'b0; i++) @(negedge core_clk);
    exp_pc = 16'h3d3c;
    check(program_counter, exp_pc);
  endtask

  task sc_seq;
    for (int l = 1; l < 5; l++) begin
      exp_pc = exp_pc + 16'(l);
      issue(btau_pkg::BTAU_SEQ, 3'(l), 1'b0);
    end
  endtask

  task sc_rel;
    for (int k = 0; k < 4; k++) begin
      disp = dtab[k];
      exp_pc = exp_pc + 16'h2 + {{8{disp[7]}}, disp};
      issue(btau_pkg::BTAU_REL, 3'h2, 1'b1);
    end
    exp_pc = exp_pc + 16'h3;
    issue(btau_pkg::BTAU_REL, 3'h3, 1'b0);
    full = 16'hfff0;
    exp_pc = 16'hfff0;
    issue(btau_pkg::BTAU_ABS16, 3'h3, 1'b0);
    disp = 8'h7f;
    exp_pc = 16'h0071;
    issue(btau_pkg::BTAU_REL, 3'h2, 1'b1);
    full = 16'h0010;
    exp_pc = 16'h0010;
    issue(btau_pkg::BTAU_ABS16, 3'h3, 1'b0);
    disp = 8'h80;
    exp_pc = 16'hff92;
    issue(btau_pkg::BTAU_REL, 3'h2, 1'b1);
  endtask

  task sc_fixed;
    fixed = 11'h7ff;
    exp_pc = 16'h0fff;
    issue(btau_pkg::BTAU_FIXED, 3'h3, 1'b0);
    fixed = 11'h000;
    exp_pc = 16'h0800;
    issue(btau_pkg::BTAU_FIXED, 3'h3, 1'b0);
  endtask

  // table call; a register jump held on valid while busy must be ignored
  task sc_table(input logic [7:0] op);
    logic [7:0] a;
    a = 8'h40 + {2'h0, op[5:1], 1'b0};
    exp_pc = {(a + 8'h1) ^ 8'h3c, a ^ 8'h3c};
    opcode = op;
    acc = 16'h1234;
    @(negedge core_clk);
    mode = btau_pkg::BTAU_TABLE;
    instr_len = 3'h1;
    branch_taken = 1'b0;
    instr_valid = 1'b1;
    @(negedge core_clk);
    check({15'h0, busy}, 16'h0001);
    mode = btau_pkg::BTAU_REGPAIR;
    opcode = 8'h01;
    repeat (2) @(negedge core_clk);
    instr_valid = 1'b0;
    wait_pc();
    check({15'h0, busy}, 16'h0000);
    check(mem_rd_addr, {8'h00, a + 8'h1});
    mode = btau_pkg::BTAU_SEQ;
    repeat (8) @(negedge core_clk);
    check({15'h0, pc_valid}, 16'h0000);
    check(program_counter, exp_pc);
  endtask

  task sc_reg;
    acc = 16'hbeef;
    exp_pc = 16'hbeef;
    issue(btau_pkg::BTAU_REGPAIR, 3'h1, 1'b0);
  endtask

  initial begin
    sc_reset();
    sc_seq();
    sc_rel();
    sc_fixed();
    sc_table(8'hc1);
    sc_table(8'h3e);
    sc_reg();
    sc_reset();
    sc_seq();
    test_done();
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
endmodule // testbench
